//--- hdl/axc_pkg.sv
package axc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [13:0] TMIN_LO_MS = 14'h0010;
  localparam logic [13:0] TMIN_HI_MS = 14'h2710;
  localparam logic [9:0] RATIO_LO = 10'h001;
  localparam logic [9:0] RATIO_HI = 10'h3E8;
  localparam logic [13:0] RATIO_SPAN = 14'h000A;
  localparam int FREQ_HI_KHZ = 900;
  localparam logic [15:0] FREQ_HI_CNT = 16'(FREQ_HI_KHZ * TICK_MS);
  localparam logic [5:0] DIV_STEPS = 6'h2A;
  localparam logic [1:0] MASTER_AXIS = 2'h0;

  typedef enum logic [1:0] {INV_NONE, INV_MEAS, INV_SETPT, INV_BOTH} axc_inv_t;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_NONSTOP_A, CMD_NONSTOP_EVT, CMD_NONSTOP_B, CMD_EVT_A, CMD_EVT_B,
    CMD_EVT_C, CMD_FORCED_POS, CMD_POINT
  } axc_cmd_t;
  typedef enum logic [1:0] {MOT_IDLE, MOT_NONSTOP, MOT_CHAINED, MOT_RUN} axc_mot_t;

  typedef struct packed {
    logic [1:0] enc_s1;
    logic [1:0] enc_s2;
    logic [1:0] enc_s3;
    logic evt_s1;
    logic evt_s2;
    logic evt_s3;
    logic signed [31:0] position;
    logic [5:0] event_task;
    axc_mot_t mot;
    logic stop_req;
    logic refused;
    logic done;
    logic evt_trig;
    logic [14:0] speed;
    logic [19:0] ramp_acc;
    logic [15:0] ms_cnt;
    logic ms_tick;
    logic [15:0] rate_cnt;
    logic [15:0] enc_rate;
    logic freq_err;
    logic cap_ptr;
    logic [31:0] cap1;
    logic [31:0] cap2;
    logic cap1_valid;
    logic cap2_valid;
    logic div_busy;
    logic [5:0] div_cnt;
    logic [10:0] div_rem;
    logic [41:0] div_quo;
    logic [9:0] div_den;
    logic div_neg;
    logic slave_req_d;
    logic learn;
    logic [31:0] offset;
    logic [31:0] slave_sp;
    logic slave_active;
    logic [15:0] dac;
  } axc_state_t;
endpackage

//--- hdl/axc_axis.sv
`timescale 1ns/1ps
`default_nettype none
module axc_axis
  import axc_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_axis_num,
  input wire logic [5:0] i_event_task,
  input wire logic [1:0] i_inv_mode,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_event_in,
  input wire logic i_seq_ctrl_disable,
  input wire logic i_cmd_valid,
  input wire logic [3:0] i_cmd_code,
  input wire logic i_next_cmd_pending,
  input wire logic i_move_end,
  input wire logic i_dir_neg,
  input wire logic [14:0] i_target_speed,
  input wire logic [14:0] i_top_speed,
  input wire logic [13:0] i_accel_limit,
  input wire logic [13:0] i_decel_limit,
  input wire logic i_slave_enable,
  input wire logic i_slave_from_meas,
  input wire logic [31:0] i_master_setpoint,
  input wire logic [31:0] i_master_position,
  input wire logic [9:0] i_ratio_num,
  input wire logic [9:0] i_ratio_den,
  input wire logic i_auto_offset,
  input wire logic [31:0] i_offset,
  input wire logic i_evt_falling,
  input wire logic i_cap_two,
  input wire logic i_cap1_falling,
  input wire logic i_cap2_falling,
  input wire logic i_cap_clear,
  output logic [5:0] o_event_task,
  output logic [31:0] o_position,
  output logic [15:0] o_dac_setpoint,
  output logic o_moving,
  output logic [14:0] o_speed,
  output logic o_stop_req,
  output logic o_cmd_refused,
  output logic o_move_done,
  output logic o_evt_trig,
  output logic [31:0] o_first_captured_position,
  output logic [31:0] o_second_captured_position,
  output logic o_first_cap_valid,
  output logic o_second_cap_valid,
  output logic [31:0] o_slave_setpoint,
  output logic o_slave_active,
  output logic [15:0] o_enc_rate,
  output logic o_encoder_freq_limit_err
);
  axc_state_t s_ff;
  axc_state_t nxt_s;

  function automatic logic [13:0] clamp_tmin(input logic [13:0] v);
    if (v < TMIN_LO_MS) return TMIN_LO_MS;
    if (v > TMIN_HI_MS) return TMIN_HI_MS;
    return v;
  endfunction

  function automatic logic [9:0] clamp_field(input logic [9:0] v);
    if (v < RATIO_LO) return RATIO_LO;
    if (v > RATIO_HI) return RATIO_HI;
    return v;
  endfunction

  logic a_now, b_now, a_old, b_old, enc_step, enc_up;
  logic evt_rise, evt_fall, hit1, hit2, seq_on, nonstop_cmd, chain_cmd;
  logic [14:0] speed_tgt, top;
  logic [13:0] tmin;
  logic [9:0] den_eff, num_eff;
  logic [13:0] num_x10, den_x10;
  logic [31:0] master_sel, master_mag, quo32;
  logic slave_req;

  always_comb begin
    a_now = s_ff.enc_s2[0];
    b_now = s_ff.enc_s2[1];
    a_old = s_ff.enc_s3[0];
    b_old = s_ff.enc_s3[1];
    enc_step = (a_now ^ a_old) ^ (b_now ^ b_old);
    enc_up = (a_old ^ b_now) ^ i_inv_mode[0];
    evt_rise = s_ff.evt_s2 & ~s_ff.evt_s3;
    evt_fall = ~s_ff.evt_s2 & s_ff.evt_s3;
    hit1 = i_cap1_falling ? evt_fall : evt_rise;
    hit2 = i_cap2_falling ? evt_fall : evt_rise;
    seq_on = ~i_seq_ctrl_disable;
    nonstop_cmd = (i_cmd_code == CMD_NONSTOP_A) || (i_cmd_code == CMD_NONSTOP_EVT) ||
                  (i_cmd_code == CMD_NONSTOP_B);
    chain_cmd = (i_cmd_code == CMD_EVT_A) || (i_cmd_code == CMD_EVT_B) ||
                (i_cmd_code == CMD_FORCED_POS);
    top = i_top_speed;
    speed_tgt = (s_ff.mot == MOT_IDLE) ? 15'h0000 :
                ((i_target_speed > top) ? top : i_target_speed);
    tmin = clamp_tmin((s_ff.speed < speed_tgt) ? i_accel_limit : i_decel_limit);
    den_eff = clamp_field(i_ratio_den);
    num_eff = clamp_field(i_ratio_num);
    num_x10 = 14'(num_eff) * RATIO_SPAN;
    den_x10 = 14'(den_eff) * RATIO_SPAN;
    if (num_x10 < 14'(den_eff)) num_eff = 10'((den_eff + 10'h009) / 10'h00A);
    else if (14'(num_eff) > den_x10) num_eff = 10'(den_x10);
    master_sel = i_slave_from_meas ? i_master_position : i_master_setpoint;
    master_mag = master_sel[31] ? 32'(-master_sel) : master_sel;
    quo32 = s_ff.div_neg ? 32'(-s_ff.div_quo[31:0]) : s_ff.div_quo[31:0];
    slave_req = i_slave_enable && (i_axis_num != MASTER_AXIS);
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.enc_s1 = {i_enc_b, i_enc_a};
    nxt_s.enc_s2 = s_ff.enc_s1;
    nxt_s.enc_s3 = s_ff.enc_s2;
    nxt_s.evt_s1 = i_event_in;
    nxt_s.evt_s2 = s_ff.evt_s1;
    nxt_s.evt_s3 = s_ff.evt_s2;
    nxt_s.event_task = i_event_task;
    nxt_s.stop_req = 1'b0;
    nxt_s.refused = 1'b0;
    nxt_s.done = 1'b0;
    nxt_s.ms_tick = 1'b0;
    if (enc_step) begin
      nxt_s.position = enc_up ? s_ff.position + 32'sh1 : s_ff.position - 32'sh1;
    end
    // Frequency window of one tick
    if (s_ff.ms_cnt == 16'(P_MS_CYCLES - 1)) begin
      nxt_s.ms_cnt = 16'h0000;
      nxt_s.ms_tick = 1'b1;
      nxt_s.enc_rate = s_ff.rate_cnt;
      nxt_s.freq_err = s_ff.rate_cnt >= FREQ_HI_CNT;
      nxt_s.rate_cnt = {15'h0000, enc_step};
    end else begin
      nxt_s.ms_cnt = s_ff.ms_cnt + 16'h0001;
      if (enc_step && s_ff.rate_cnt != 16'hFFFF) nxt_s.rate_cnt = s_ff.rate_cnt + 16'h0001;
    end
    // Move sequencing
    if (i_cmd_valid && i_cmd_code != CMD_NONE) begin
      if (nonstop_cmd) nxt_s.mot = MOT_NONSTOP;
      else if (chain_cmd && s_ff.mot == MOT_NONSTOP) nxt_s.mot = MOT_CHAINED;
      else nxt_s.mot = MOT_RUN;
    end else if (i_move_end) begin
      case (s_ff.mot)
        MOT_NONSTOP: begin
          if (i_next_cmd_pending) begin
            nxt_s.mot = MOT_IDLE;
          end else if (seq_on) begin
            nxt_s.mot = MOT_IDLE;
            nxt_s.stop_req = 1'b1;
            nxt_s.refused = 1'b1;
          end
        end
        MOT_CHAINED: begin
          nxt_s.mot = MOT_IDLE;
          if (!i_next_cmd_pending && seq_on) nxt_s.stop_req = 1'b1;
          else nxt_s.done = 1'b1;
        end
        MOT_RUN: begin
          nxt_s.mot = MOT_IDLE;
          nxt_s.done = 1'b1;
        end
        default: nxt_s.mot = MOT_IDLE;
      endcase
    end
    // Ramp: top speed gained over tmin milliseconds
    if (s_ff.speed == speed_tgt) begin
      nxt_s.ramp_acc = 20'h00000;
    end else if (s_ff.ms_tick) begin
      nxt_s.ramp_acc = s_ff.ramp_acc + 20'(top);
    end else if (s_ff.ramp_acc >= 20'(tmin)) begin
      nxt_s.ramp_acc = s_ff.ramp_acc - 20'(tmin);
      nxt_s.speed = (s_ff.speed < speed_tgt) ? s_ff.speed + 15'h0001 : s_ff.speed - 15'h0001;
    end
    nxt_s.dac = (i_dir_neg ^ i_inv_mode[1]) ? 16'(-{1'b0, s_ff.speed}) : {1'b0, s_ff.speed};
    // Event edge and capture
    nxt_s.evt_trig = i_evt_falling ? evt_fall : evt_rise;
    if (i_cap_clear) begin
      nxt_s.cap1_valid = 1'b0;
      nxt_s.cap2_valid = 1'b0;
    end
    if (!i_cap_two) begin
      nxt_s.cap_ptr = 1'b0;
      if (hit1) begin
        nxt_s.cap1 = s_ff.position;
        nxt_s.cap1_valid = 1'b1;
      end
    end else if (!s_ff.cap_ptr && hit1) begin
      nxt_s.cap1 = s_ff.position;
      nxt_s.cap1_valid = 1'b1;
      nxt_s.cap_ptr = 1'b1;
    end else if (s_ff.cap_ptr && hit2) begin
      nxt_s.cap2 = s_ff.position;
      nxt_s.cap2_valid = 1'b1;
      nxt_s.cap_ptr = 1'b0;
    end
    // Slaving: sequential divide of master times numerator by denominator
    nxt_s.slave_req_d = slave_req;
    nxt_s.slave_active = slave_req;
    if (slave_req && !s_ff.slave_req_d) nxt_s.learn = i_auto_offset;
    if (!slave_req) nxt_s.learn = 1'b0;
    if (!s_ff.div_busy) begin
      if (slave_req) begin
        nxt_s.div_busy = 1'b1;
        nxt_s.div_cnt = DIV_STEPS;
        nxt_s.div_rem = 11'h000;
        nxt_s.div_quo = 42'(master_mag) * 42'(num_eff);
        nxt_s.div_den = den_eff;
        nxt_s.div_neg = master_sel[31];
      end
    end else if (s_ff.div_cnt != 6'h00) begin
      nxt_s.div_cnt = s_ff.div_cnt - 6'h01;
      nxt_s.div_rem = {s_ff.div_rem[9:0], s_ff.div_quo[41]};
      nxt_s.div_quo = {s_ff.div_quo[40:0], 1'b0};
      if (nxt_s.div_rem >= {1'b0, s_ff.div_den}) begin
        nxt_s.div_rem = nxt_s.div_rem - {1'b0, s_ff.div_den};
        nxt_s.div_quo[0] = 1'b1;
      end
    end else begin
      nxt_s.div_busy = 1'b0;
      if (slave_req) begin
        if (s_ff.learn) begin
          nxt_s.offset = s_ff.position - quo32;
          nxt_s.learn = 1'b0;
          nxt_s.slave_sp = s_ff.position;
        end else begin
          nxt_s.slave_sp = quo32 + (i_auto_offset ? s_ff.offset : i_offset);
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_event_task = s_ff.event_task;
  assign o_position = s_ff.position;
  assign o_dac_setpoint = s_ff.dac;
  assign o_moving = s_ff.mot != MOT_IDLE;
  assign o_speed = s_ff.speed;
  assign o_stop_req = s_ff.stop_req;
  assign o_cmd_refused = s_ff.refused;
  assign o_move_done = s_ff.done;
  assign o_evt_trig = s_ff.evt_trig;
  assign o_first_captured_position = s_ff.cap1;
  assign o_second_captured_position = s_ff.cap2;
  assign o_first_cap_valid = s_ff.cap1_valid;
  assign o_second_cap_valid = s_ff.cap2_valid;
  assign o_slave_setpoint = s_ff.slave_sp;
  assign o_slave_active = s_ff.slave_active;
  assign o_enc_rate = s_ff.enc_rate;
  assign o_encoder_freq_limit_err = s_ff.freq_err;

  AST_SEQ_STOP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_ff.mot == MOT_NONSTOP && i_move_end && !i_cmd_valid && !i_next_cmd_pending && seq_on)
    |=> (o_stop_req && o_cmd_refused && !o_moving))
    else $error("nonstop move not halted with refusal");
  AST_SEQ_OFF_RUN: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_ff.mot == MOT_NONSTOP && i_move_end && !i_cmd_valid && !i_next_cmd_pending && !seq_on)
    |=> (!o_stop_req && o_moving))
    else $error("nonstop move stopped with sequence control off");
  AST_CHAIN_STOP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_ff.mot == MOT_CHAINED && i_move_end && !i_cmd_valid && !i_next_cmd_pending && seq_on)
    |=> (o_stop_req && !o_cmd_refused && !o_move_done))
    else $error("chained command not halted");
  AST_TMIN_RANGE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (tmin >= TMIN_LO_MS) && (tmin <= TMIN_HI_MS))
    else $error("ramp time out of range");
  AST_RATIO_RANGE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (14'(num_eff) * RATIO_SPAN >= 14'(den_eff)) && (14'(num_eff) <= den_x10))
    else $error("ratio outside 0.1 to 10");
  AST_MASTER_ONLY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_axis_num == MASTER_AXIS) |=> !o_slave_active)
    else $error("axis zero acting as slave");
  AST_EVT_EDGE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!i_evt_falling && $rose(s_ff.evt_s2)) |=> o_evt_trig)
    else $error("selected event edge missed");
  AST_CAP_SECOND: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_cap_two && s_ff.cap_ptr && hit2) |=> (o_second_captured_position == $past(o_position)
    && !s_ff.cap_ptr))
    else $error("second capture not taken");
  AST_CAP_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !hit1 |=> $stable(o_first_captured_position))
    else $error("first capture changed without edge");
  AST_MEAS_INV: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (enc_step && (a_old ^ b_now) && i_inv_mode[0]) |=> (o_position == $past(o_position) - 1))
    else $error("measurement inversion not applied");
endmodule // axc_axis
`default_nettype wire

//--- verif/axc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module axc_far_side (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_back,
  input wire logic [7:0] i_steps,
  input wire logic i_evt_lvl,
  output logic o_enc_a,
  output logic o_enc_b,
  output logic o_event_in,
  output logic o_busy
);
  logic [1:0] ph = 2'h0;
  logic [1:0] div = 2'h0;
  logic [7:0] left = 8'h00;
  // Gray phase: forward runs 00, 01, 11, 10 on {a, b}
  assign o_enc_a = ph[1];
  assign o_enc_b = ph[1] ^ ph[0];
  assign o_busy = (left != 8'h00);
  initial o_event_in = 1'b0;
  always @(posedge i_clk) begin
    o_event_in <= i_evt_lvl;
    div <= div + 2'h1;
    if (i_go) begin
      left <= i_steps;
    end else if (o_busy && div == 2'h3) begin
      ph <= i_back ? ph - 2'h1 : ph + 2'h1;
      left <= left - 8'h01;
    end
  end
endmodule // axc_far_side
`default_nettype wire

//--- verif/test_axis_motion_config_capture.sv
`timescale 1ns/1ps
`default_nettype none
module test_axis_motion_config_capture;
  import axc_pkg::*;
  localparam int MSC = 50;
  logic i_clk = 1'b0;
  logic i_rstn, i_enc_a, i_enc_b, i_event_in, i_seq_ctrl_disable, i_cmd_valid, i_move_end;
  logic i_next_cmd_pending, i_dir_neg, i_slave_enable, i_slave_from_meas, i_auto_offset;
  logic i_evt_falling, i_cap_two, i_cap1_falling, i_cap2_falling, i_cap_clear;
  logic [1:0] i_axis_num, i_inv_mode;
  logic [5:0] i_event_task, o_event_task;
  logic [3:0] i_cmd_code;
  logic [14:0] i_target_speed, i_top_speed, o_speed;
  logic [13:0] i_accel_limit, i_decel_limit;
  logic [31:0] i_master_setpoint, i_master_position, i_offset, o_position, o_slave_setpoint;
  logic [9:0] i_ratio_num, i_ratio_den;
  logic [15:0] o_dac_setpoint, o_enc_rate;
  logic o_moving, o_stop_req, o_cmd_refused, o_move_done, o_evt_trig, o_slave_active;
  logic o_first_cap_valid, o_second_cap_valid, o_encoder_freq_limit_err;
  logic [31:0] o_first_captured_position, o_second_captured_position;
  logic p_go, p_back, p_evt, p_busy;
  logic [7:0] p_steps, n;
  logic [31:0] pos_exp, p1, act, want;
  logic [2:0] seen = 3'h0;
  logic trig_seen = 1'b0;
  logic [3:0] fol [3] = '{4'h4, 4'h5, 4'h7};
  integer seed = 32'h8FB01BBF;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int sel_q [$];
  logic [31:0] exp_q [$];
  event sample_ev;

  axc_axis #(.P_MS_CYCLES(MSC)) DUT (.i_clk, .i_rstn, .i_axis_num, .i_event_task, .i_inv_mode,
    .i_enc_a, .i_enc_b, .i_event_in, .i_seq_ctrl_disable, .i_cmd_valid, .i_cmd_code,
    .i_next_cmd_pending, .i_move_end, .i_dir_neg, .i_target_speed, .i_top_speed,
    .i_accel_limit, .i_decel_limit, .i_slave_enable, .i_slave_from_meas, .i_master_setpoint,
    .i_master_position, .i_ratio_num, .i_ratio_den, .i_auto_offset, .i_offset, .i_evt_falling,
    .i_cap_two, .i_cap1_falling, .i_cap2_falling, .i_cap_clear, .o_event_task, .o_position,
    .o_dac_setpoint, .o_moving, .o_speed, .o_stop_req, .o_cmd_refused, .o_move_done,
    .o_evt_trig, .o_first_captured_position, .o_second_captured_position, .o_first_cap_valid,
    .o_second_cap_valid, .o_slave_setpoint, .o_slave_active, .o_enc_rate,
    .o_encoder_freq_limit_err);
  axc_far_side far (.i_clk, .i_go(p_go), .i_back(p_back), .i_steps(p_steps), .i_evt_lvl(p_evt),
    .o_enc_a(i_enc_a), .o_enc_b(i_enc_b), .o_event_in(i_event_in), .o_busy(p_busy));

  initial forever #10 i_clk = ~i_clk;
  // Sticky {stop, refused, done} so one-cycle pulses are not missed
  always @(posedge i_clk) seen <= seen | {o_stop_req, o_cmd_refused, o_move_done};
  always @(posedge i_clk) trig_seen <= trig_seen | o_evt_trig;

  function automatic logic [31:0] observe(input int s);
    case (s)
      0: return o_position;
      1: return {26'h0, o_event_task};
      2: return o_first_captured_position;
      3: return o_second_captured_position;
      4: return {30'h0, o_second_cap_valid, o_first_cap_valid};
      5: return {28'h0, seen, o_moving};
      6: return {31'h0, o_speed === i_top_speed};
      7: return o_slave_setpoint;
      8: return {31'h0, o_slave_active};
      10: return {30'h0, o_encoder_freq_limit_err,
                  (o_enc_rate == 16'(MSC / 4)) || (o_enc_rate == 16'(MSC / 4 + 1))};
      11: return {31'h0, trig_seen};
      default: return {31'h0, o_dac_setpoint[15]};
    endcase
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input int s, input logic [31:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
    ->sample_ev;
  endtask
  initial forever begin
    @(sample_ev);
    @(negedge i_clk);
    while (exp_q.size() > 0) begin
      want = exp_q.pop_front();
      act = observe(sel_q.pop_front());
      samples_checked = samples_checked + 1;
      if (act !== want) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, act, want);
      end
    end
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic cmd(input logic [3:0] c);
    i_cmd_code = c;
    i_cmd_valid = 1'b1;
    cyc(1);
    i_cmd_valid = 1'b0;
  endtask
  task automatic end_move();
    seen = 3'h0;
    i_move_end = 1'b1;
    cyc(1);
    i_move_end = 1'b0;
    cyc(3);
  endtask
  task automatic steps(input logic back, input logic [7:0] k);
    p_back = back;
    p_steps = k;
    p_go = 1'b1;
    cyc(1);
    p_go = 1'b0;
    for (int w = 0; w < 1200 && p_busy; w++) cyc(1);
    cyc(6);
  endtask
  task automatic evt(input logic lvl);
    p_evt = lvl;
    cyc(8);
  endtask

  initial begin
    {i_rstn, i_seq_ctrl_disable, i_cmd_valid, i_move_end, i_next_cmd_pending} = 5'h0;
    {i_dir_neg, i_slave_enable, i_slave_from_meas, i_auto_offset, i_evt_falling} = 5'h0;
    {i_cap_two, i_cap1_falling, i_cap2_falling, i_cap_clear, p_go, p_back, p_evt} = 7'h0;
    {i_axis_num, i_inv_mode, i_event_task, i_cmd_code, p_steps} = 22'h0;
    {i_target_speed, i_top_speed, i_accel_limit} = 44'h0;
    i_decel_limit = 14'h0010;
    {i_master_setpoint, i_master_position, i_offset} = 96'h0;
    i_ratio_num = 10'h001;
    i_ratio_den = 10'h001;
    pos_exp = 32'h0;
    cyc(5);
    i_rstn = 1'b1;
    check(0, 32'h0);
    repeat (4) begin
      {i_evt_falling, i_event_task} = 7'($random(seed));
      cyc(2);
      check(1, {26'h0, i_event_task});
    end
    $display("end of test: event task");
    for (int m = 0; m < 4; m++) begin
      i_inv_mode = 2'(m);
      n = 8'($random(seed)) % 8'h20 + 8'h04;
      steps(1'b0, n);
      pos_exp = m[0] ? pos_exp - 32'(n) : pos_exp + 32'(n);
      check(0, pos_exp);
      steps(1'b1, 8'h03);
      pos_exp = m[0] ? pos_exp + 32'h3 : pos_exp - 32'h3;
      check(0, pos_exp);
    end
    p_back = 1'b0;
    p_steps = 8'h40;
    p_go = 1'b1;
    cyc(1);
    p_go = 1'b0;
    cyc(MSC * 3);
    check(10, 32'h1);
    cyc(MSC * 3);
    pos_exp = pos_exp - 32'h40;
    check(0, pos_exp);
    $display("end of test: inversion");
    // Ramp time below the minimum held at 16 ms; DAC sign follows direction and inversion
    i_top_speed = 15'h0028;
    i_target_speed = 15'h0028;
    i_accel_limit = 14'h0005;
    i_inv_mode = 2'h2;
    cmd(4'h8);
    cyc(MSC * 8);
    check(6, 32'h0);
    cyc(MSC * 12);
    check(6, 32'h1);
    check(9, 32'h1);
    i_dir_neg = 1'b1;
    cyc(2);
    check(9, 32'h0);
    i_inv_mode = 2'h0;
    cyc(2);
    check(9, 32'h1);
    i_dir_neg = 1'b0;
    end_move();
    check(5, 32'h2);
    $display("end of test: ramp");
    for (int c = 1; c < 4; c++) begin
      cmd(4'(c));
      cyc(3);
      end_move();
      check(5, 32'hC);
    end
    i_next_cmd_pending = 1'b1;
    cmd(4'h2);
    cyc(3);
    end_move();
    check(5, 32'h0);
    i_next_cmd_pending = 1'b0;
    foreach (fol[k]) begin
      // Chain issued one idle cycle apart, never waiting on done
      cmd(4'h1);
      cyc(1);
      cmd(fol[k]);
      cyc(2);
      end_move();
      check(5, 32'h8);
    end
    cmd(4'h1);
    cyc(1);
    cmd(4'h6);
    cyc(2);
    end_move();
    check(5, 32'h2);
    i_seq_ctrl_disable = 1'b1;
    cmd(4'h3);
    cyc(3);
    end_move();
    check(5, 32'h1);
    i_seq_ctrl_disable = 1'b0;
    cmd(4'h8);
    cyc(2);
    end_move();
    check(5, 32'h2);
    $display("end of test: sequence control");
    i_cap_clear = 1'b1;
    cyc(1);
    i_cap_clear = 1'b0;
    i_cap1_falling = 1'b1;
    i_evt_falling = 1'b1;
    trig_seen = 1'b0;
    evt(1'b1);
    check(4, 32'h0);
    check(11, 32'h0);
    evt(1'b0);
    check(4, 32'h1);
    check(11, 32'h1);
    check(2, pos_exp);
    steps(1'b0, 8'h05);
    i_evt_falling = 1'b0;
    trig_seen = 1'b0;
    evt(1'b1);
    check(2, pos_exp);
    check(11, 32'h1);
    pos_exp = pos_exp + 32'h5;
    for (int cm = 0; cm < 4; cm++) begin
      i_cap_two = 1'b0;
      {i_cap1_falling, i_cap2_falling} = 2'(cm);
      evt(i_cap1_falling);
      i_cap_two = 1'b1;
      evt(~p_evt);
      p1 = pos_exp;
      steps(1'b0, 8'h03);
      pos_exp = pos_exp + 32'h3;
      if (p_evt != i_cap2_falling) evt(~p_evt);
      evt(~p_evt);
      check(2, p1);
      check(3, pos_exp);
    end
    $display("end of test: capture");
    i_axis_num = 2'h1;
    i_master_setpoint = 32'h000003E8;
    i_master_position = 32'h00000064;
    i_ratio_num = 10'h003;
    i_ratio_den = 10'h002;
    i_offset = 32'h00000005;
    i_slave_enable = 1'b1;
    cyc(100);
    check(8, 32'h1);
    check(7, 32'h000005E1);
    i_slave_from_meas = 1'b1;
    cyc(100);
    check(7, 32'h0000009B);
    i_slave_from_meas = 1'b0;
    i_ratio_num = 10'h001;
    i_ratio_den = 10'h3E8;
    cyc(100);
    check(7, 32'h00000069);
    i_slave_enable = 1'b0;
    cyc(2);
    i_auto_offset = 1'b1;
    i_slave_enable = 1'b1;
    cyc(100);
    check(7, pos_exp);
    i_axis_num = 2'h0;
    cyc(100);
    check(8, 32'h0);
    $display("end of test: slaving");
    cyc(1);
    give_verdict();
  end
endmodule // test_axis_motion_config_capture
`default_nettype wire
